//--- lmp_pkg.sv
/*
  Constants for the display module host bus port: pin vector layout,
  reset values, buffer sizing and cycle-tracking states.
  Assumes a single 125 MHz reference clock and a synchronous reset.
*/
`default_nettype none
package lmp_pkg;
  // Data bus width
  localparam int unsigned LMP_DATA_W      = 8;
  // Buffer depth in words
  localparam int unsigned LMP_FIFO_DEPTH  = 16;
  // Buffer word: command flag above the data byte
  localparam int unsigned LMP_WORD_W      = LMP_DATA_W + 1;
  // Pin vector layout
  localparam int unsigned LMP_PIN_RST_N   = 0;
  localparam int unsigned LMP_PIN_CS_N    = 1;
  localparam int unsigned LMP_PIN_RS      = 2;
  localparam int unsigned LMP_PIN_STYLE   = 3;
  localparam int unsigned LMP_PIN_WR_RW   = 4;
  localparam int unsigned LMP_PIN_RD_EN   = 5;
  localparam int unsigned LMP_PIN_DATA_LO = 6;
  localparam int unsigned LMP_PIN_W       = LMP_PIN_DATA_LO + LMP_DATA_W;
  // Idle pin levels: reset released, deselected, enable style with enable low
  // and direction high, so no strobe edge is seen as the stages fill
  localparam logic [13:0] LMP_PIN_RST_VAL = 14'h001B;
  // Byte driven while the bus is released
  localparam logic [7:0]  LMP_BUS_RST_VAL = 8'h00;
  // Bus style codes on the select pin
  localparam logic        LMP_STYLE_ENABLE = 1'h1;
  localparam logic        LMP_STYLE_STROBE = 1'h0;
  // Read cycle tracking
  typedef enum logic [0:0] {
    LMP_ST_IDLE = 1'b0,
    LMP_ST_READ = 1'b1
  } lmp_state_t;
endpackage : lmp_pkg
`default_nettype wire

//--- lmp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides; width and depth
  are parameters. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module lmp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];   // Storage array
  logic [AW-1:0]    wr_ptr;        // Next slot to fill
  logic [AW-1:0]    rd_ptr;        // Oldest slot
  logic [AW:0]      count;         // Words held
  logic             push;          // Accepted write
  logic             pop;           // Accepted read

  // Honest flags straight from the count
  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage write; no reset needed on data
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers wrap at DEPTH, so any depth works
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule : lmp_fifo
`default_nettype wire

//--- lmp_host_port.sv
/*
  Host bus port of a graphic display module: decodes host writes
  (command or data/parameter) into a buffered stream and answers host
  reads with status or display data. Supports strobe style and
  enable-plus-direction style, chosen by a static pin.
  Assumes all host pins are asynchronous to i_ref_clk and that host
  strobes last several reference clocks; the user side is synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module lmp_host_port
  import lmp_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = LMP_FIFO_DEPTH
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_srst,
  // Host pins
  input  wire logic                  i_reset_n,
  input  wire logic                  i_chip_select_n,
  input  wire logic                  i_register_select,
  input  wire logic                  i_bus_style_select,
  input  wire logic                  i_write_n_dir,
  input  wire logic                  i_read_n_enable,
  input  wire logic [LMP_DATA_W-1:0] i_data_bus,
  output logic      [LMP_DATA_W-1:0] o_data_bus,
  output logic                       o_data_bus_oe,
  // Write stream to the controller core
  output logic                       o_wr_valid,
  input  wire logic                  i_wr_ready,
  output logic                       o_wr_is_command,
  output logic      [LMP_DATA_W-1:0] o_wr_data,
  output logic                       o_wr_overrun,
  output logic                       o_wr_buf_ready,
  // Read sources from the controller core
  input  wire logic [LMP_DATA_W-1:0] i_status_byte,
  input  wire logic [LMP_DATA_W-1:0] i_read_byte,
  output logic                       o_read_taken,
  output logic                       o_in_reset
);

  logic [LMP_PIN_W-1:0]  pins;       // Raw pin vector
  logic [LMP_PIN_W-1:0]  sync1;      // First stage, read only by sync2
  logic [LMP_PIN_W-1:0]  sync2;      // Second stage
  logic [LMP_PIN_W-1:0]  sync3;      // Third stage
  logic [LMP_PIN_W-1:0]  filt;       // Agreed pin levels
  logic                  prev_wr;    // Last agreed write/direction pin
  logic                  prev_rd;    // Last agreed read/enable pin
  logic                  dev_rst;    // Combined device reset
  logic                  selected;   // Chip select asserted
  logic                  style_en;   // Enable-plus-direction style
  logic                  rd_active;  // Host is in a selected read
  logic                  wr_event;   // Host write completed this cycle
  logic [LMP_WORD_W-1:0] wr_word;    // Flag and byte for the buffer
  logic                  buf_ready;  // Buffer can take a word
  logic                  buf_valid;  // Buffer holds a word
  logic [LMP_WORD_W-1:0] buf_word;   // Oldest buffered word
  logic                  buf_pop;    // Move word to output stage
  lmp_state_t            state;      // Read cycle tracking
  lmp_state_t            next_state; // Next tracking state
  logic                  read_rs;    // Select level held for this read

  assign pins = {i_data_bus, i_read_n_enable, i_write_n_dir, i_bus_style_select,
                 i_register_select, i_chip_select_n, i_reset_n};

  // Three-stage synchroniser per pin; a level counts once stages two
  // and three agree, which also rejects single-sample glitches
  genvar g;
  generate
    for (g = 0; g < LMP_PIN_W; g++) begin : g_pin
      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          sync1[g] <= LMP_PIN_RST_VAL[g];
          sync2[g] <= LMP_PIN_RST_VAL[g];
          sync3[g] <= LMP_PIN_RST_VAL[g];
          filt[g]  <= LMP_PIN_RST_VAL[g];
        end else begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            filt[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  // Pin reset is active low; synchronisers stay alive so release is seen
  assign dev_rst  = i_srst || !filt[LMP_PIN_RST_N];
  assign selected = !filt[LMP_PIN_CS_N];
  assign style_en = (filt[LMP_PIN_STYLE] == LMP_STYLE_ENABLE);

  // Read window: low read strobe, or high enable with direction high
  always_comb begin
    if (style_en) begin
      rd_active = selected && filt[LMP_PIN_RD_EN] && filt[LMP_PIN_WR_RW];
    end else begin
      rd_active = selected && !filt[LMP_PIN_RD_EN];
    end
  end

  // Write completion edge; deselected strobes never count
  always_comb begin
    if (style_en) begin
      wr_event = selected && !filt[LMP_PIN_WR_RW]
                 && prev_rd && !filt[LMP_PIN_RD_EN];
    end else begin
      wr_event = selected && !prev_wr && filt[LMP_PIN_WR_RW];
    end
    wr_event = wr_event && !dev_rst;
  end

  // Select high marks a command code, low marks data or parameter
  assign wr_word = {filt[LMP_PIN_RS],
                    filt[LMP_PIN_DATA_LO +: LMP_DATA_W]};

  // Strobe history for edge detection
  always_ff @(posedge i_ref_clk) begin
    if (dev_rst) begin
      prev_wr <= LMP_PIN_RST_VAL[LMP_PIN_WR_RW];
      prev_rd <= LMP_PIN_RST_VAL[LMP_PIN_RD_EN];
    end else begin
      prev_wr <= filt[LMP_PIN_WR_RW];
      prev_rd <= filt[LMP_PIN_RD_EN];
    end
  end

  // Host writes cannot be stalled, so the buffer absorbs bursts
  lmp_fifo #(
    .WIDTH (LMP_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (dev_rst),
    .i_in_valid  (wr_event),
    .o_in_ready  (buf_ready),
    .i_in_data   (wr_word),
    .o_out_valid (buf_valid),
    .i_out_ready (buf_pop),
    .o_out_data  (buf_word)
  );

  // Output stage refills when empty or when the core takes the word
  assign buf_pop = buf_valid && (!o_wr_valid || i_wr_ready);

  // Registered write stream toward the core
  always_ff @(posedge i_ref_clk) begin
    if (dev_rst) begin
      o_wr_valid      <= 1'b0;
      o_wr_is_command <= 1'b0;
      o_wr_data       <= LMP_BUS_RST_VAL;
    end else if (buf_pop) begin
      o_wr_valid      <= 1'b1;
      o_wr_is_command <= buf_word[LMP_DATA_W];
      o_wr_data       <= buf_word[LMP_DATA_W-1:0];
    end else if (i_wr_ready) begin
      o_wr_valid      <= 1'b0;
    end
  end

  // Buffer status; an overrun loses the byte since the host has no wait pin
  always_ff @(posedge i_ref_clk) begin
    if (dev_rst) begin
      o_wr_buf_ready <= 1'b0;
      o_wr_overrun   <= 1'b0;
    end else begin
      o_wr_buf_ready <= buf_ready;
      o_wr_overrun   <= wr_event && !buf_ready;
    end
  end

  // Read tracking: select level fixed at the start of each read
  always_comb begin
    next_state = state;
    case (state)
      LMP_ST_IDLE: begin
        if (rd_active) begin
          next_state = LMP_ST_READ;
        end
      end
      LMP_ST_READ: begin
        if (!rd_active) begin
          next_state = LMP_ST_IDLE;
        end
      end
      default: begin
        next_state = LMP_ST_IDLE;
      end
    endcase
  end

  // State and held select level
  always_ff @(posedge i_ref_clk) begin
    if (dev_rst) begin
      state   <= LMP_ST_IDLE;
      read_rs <= 1'b0;
    end else begin
      state <= next_state;
      if (state == LMP_ST_IDLE && rd_active) begin
        read_rs <= filt[LMP_PIN_RS];
      end
    end
  end

  // Drive the bus only inside a selected read; released otherwise
  always_ff @(posedge i_ref_clk) begin
    if (dev_rst) begin
      o_data_bus_oe <= 1'b0;
      o_data_bus    <= LMP_BUS_RST_VAL;
    end else begin
      o_data_bus_oe <= rd_active;
      if (!rd_active) begin
        o_data_bus <= LMP_BUS_RST_VAL;
      end else if (filt[LMP_PIN_RS]) begin
        o_data_bus <= i_read_byte;
      end else begin
        o_data_bus <= i_status_byte;
      end
    end
  end

  // Data reads advance the core's pointer once, at the end of the read;
  // status reads have no side effect
  always_ff @(posedge i_ref_clk) begin
    if (dev_rst) begin
      o_read_taken <= 1'b0;
    end else begin
      o_read_taken <= (state == LMP_ST_READ) && !rd_active && read_rs;
    end
  end

  // Reset indication for the core
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_in_reset <= 1'b1;
    end else begin
      o_in_reset <= !filt[LMP_PIN_RST_N];
    end
  end
endmodule : lmp_host_port
`default_nettype wire

//--- lmp_host_port_asserts.sv
/*
  Checker for the host bus port: bus release, read answers, write hold.
  Assumes it is bound to lmp_host_port by the bench top file.
*/
`timescale 1ns/1ns
`default_nettype none
module lmp_host_port_asserts
  import lmp_pkg::*;
(
  input wire logic                  i_ref_clk,
  input wire logic                  i_srst,
  input wire logic                  i_reset_n,
  input wire logic                  i_chip_select_n,
  input wire logic                  i_register_select,
  input wire logic                  i_bus_style_select,
  input wire logic                  i_write_n_dir,
  input wire logic                  i_read_n_enable,
  input wire logic [LMP_DATA_W-1:0] o_data_bus,
  input wire logic                  o_data_bus_oe,
  input wire logic                  o_wr_valid,
  input wire logic                  i_wr_ready,
  input wire logic                  o_wr_is_command,
  input wire logic [LMP_DATA_W-1:0] o_wr_data,
  input wire logic [LMP_DATA_W-1:0] i_status_byte,
  input wire logic [LMP_DATA_W-1:0] i_read_byte,
  input wire logic                  o_read_taken,
  input wire logic                  o_in_reset
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic [3:0] desel_cnt; // Cycles deselected, saturating
  // Counts deselect; pin sync delay is why eight cycles are allowed
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !i_chip_select_n) desel_cnt <= 4'h0;
    else if (desel_cnt != 4'hF) desel_cnt <= desel_cnt + 4'h1;
  end
  // Selected read strobe held past the sync delay
  sequence strobe_rd_s;
    (!i_chip_select_n && !i_bus_style_select && !i_read_n_enable && !o_in_reset) [*7];
  endsequence
  sequence enable_rd_s;
    (!i_chip_select_n && i_bus_style_select && i_read_n_enable && i_write_n_dir
     && !o_in_reset) [*7];
  endsequence
  desel_release_a: assert property (desel_cnt >= 4'h8 |-> !o_data_bus_oe)
    else $error("bus driven while deselected");
  idle_zero_a: assert property (!o_data_bus_oe |-> o_data_bus == LMP_BUS_RST_VAL)
    else $error("bus value while released");
  read_source_a: assert property (o_data_bus_oe |-> o_data_bus ==
    ($past(i_register_select) ? $past(i_read_byte) : $past(i_status_byte)))
    else $error("read byte from wrong source");
  strobe_read_a: assert property (strobe_rd_s |-> o_data_bus_oe)
    else $error("strobe read not answered");
  enable_read_a: assert property (enable_rd_s |-> o_data_bus_oe)
    else $error("enable read not answered");
  // A pin reset may flush a stalled word; that is the only way out
  word_hold_a: assert property (o_wr_valid && !i_wr_ready |=> o_in_reset || (o_wr_valid
    && $stable(o_wr_data) && $stable(o_wr_is_command)))
    else $error("stalled word changed");
  pin_reset_a: assert property (!i_reset_n [*8] |-> o_in_reset && !o_wr_valid)
    else $error("pin reset not honoured");
  taken_end_a: assert property (o_read_taken |-> $fell(o_data_bus_oe))
    else $error("read taken outside read end");
endmodule : lmp_host_port_asserts
`default_nettype wire

//--- lmp_host_model.sv
/*
  Host processor model on the port's pins: strobe cycles in either style.
  Assumes the bench resolves the shared data pins from the port's enable.
*/
`timescale 1ns/1ns
`default_nettype none
module lmp_host_model
  import lmp_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic [LMP_DATA_W-1:0] i_data_bus,
  output logic                       o_rst_n,
  output logic                       o_cs_n,
  output logic                       o_rs,
  output logic                       o_sty,
  output logic                       o_wr,
  output logic                       o_rd,
  output logic [LMP_DATA_W-1:0]      o_d
);
  // Idle: out of reset, deselected, strobe style
  initial begin
    {o_rst_n, o_cs_n, o_rs, o_sty, o_wr, o_rd} = 6'h33;
    o_d = 8'h00;
  end
  // Reset pin level, active low
  task automatic set_rst(input logic v);
    @(posedge i_ref_clk) o_rst_n <= v;
  endtask : set_rst
  // Style only changes under reset, so no stray strobe is seen
  task automatic set_style(input logic s);
    set_rst(1'b0);
    repeat (6) @(posedge i_ref_clk);
    o_sty <= s;
    o_rd  <= !s;
    repeat (6) @(posedge i_ref_clk);
    set_rst(1'b1);
    repeat (8) @(posedge i_ref_clk);
  endtask : set_style
  // One cycle; pins held well past the port's sync delay
  task automatic xfer(input logic rd, rs, sel, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_ref_clk);
    o_cs_n <= !sel;
    o_rs   <= rs;
    o_d    <= rd ? ~o_d : d;
    o_wr   <= o_sty ? rd : 1'b1;
    @(posedge i_ref_clk);
    if (o_sty) o_rd <= 1'b1;
    else if (rd) o_rd <= 1'b0;
    else o_wr <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    q = i_data_bus;
    o_rd <= !o_sty;
    if (!o_sty) o_wr <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    o_wr   <= 1'b1;
    o_d    <= ~o_d; // Released: inverse pattern, no pull
    repeat (6) @(posedge i_ref_clk);
  endtask : xfer
endmodule : lmp_host_model
`default_nettype wire

//--- lmp_testbench.sv
/*
  Bench top: host model on the pins, stalling sink on the write stream.
  Assumes the checker is bound to the port at the foot of this file.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
  import lmp_pkg::*;
;
  localparam int unsigned DEPTH = 4; // Small buffer keeps overflow short
  logic clk, srst, ready, rst_n, cs_n, rs, sty, wr, rd, oe, cmd, val, ovr, bufr, taken, inrst;
  logic [7:0] host_d, dut_d, pin_d, w_d, q;
  logic [7:0] status = 8'h3C;
  logic [7:0] rbyte  = 8'hC3;
  logic [8:0] got[$]; // Words taken from the stream
  int mismatches, compares, cycles, n_taken, n_ovr, k;
  assign pin_d = oe ? dut_d : host_d; // Shared data pins
  lmp_host_model h (.i_ref_clk(clk), .i_data_bus(pin_d), .o_rst_n(rst_n), .o_cs_n(cs_n),
    .o_rs(rs), .o_sty(sty), .o_wr(wr), .o_rd(rd), .o_d(host_d));
  lmp_host_port #(.FIFO_DEPTH(DEPTH)) dut (.i_ref_clk(clk), .i_srst(srst), .i_reset_n(rst_n),
    .i_chip_select_n(cs_n), .i_register_select(rs), .i_bus_style_select(sty),
    .i_write_n_dir(wr), .i_read_n_enable(rd), .i_data_bus(pin_d), .o_data_bus(dut_d),
    .o_data_bus_oe(oe), .o_wr_valid(val), .i_wr_ready(ready), .o_wr_is_command(cmd),
    .o_wr_data(w_d), .o_wr_overrun(ovr), .o_wr_buf_ready(bufr), .i_status_byte(status),
    .i_read_byte(rbyte), .o_read_taken(taken), .o_in_reset(inrst));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [8:0] a, b, input string m);
    compares++;
    if (a !== b) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // Stream sink, pulse counters and hang limit
  always @(posedge clk) begin
    cycles++;
    if (val === 1'b1 && ready === 1'b1) got.push_back({cmd, w_d});
    if (taken === 1'b1) n_taken++;
    if (ovr === 1'b1) n_ovr++;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic t_writes(input logic s);
    h.set_style(s);
    got.delete();
    h.xfer(1'b0, 1'b1, 1'b1, 8'h40, q);
    h.xfer(1'b0, 1'b0, 1'b1, 8'hA5, q);
    h.xfer(1'b0, 1'b1, 1'b0, 8'h5A, q); // Deselected, must vanish
    chk(9'(got.size()), 9'h002, "write count");
    chk(got[0], 9'h140, "command word");
    chk(got[1], 9'h0A5, "data word");
  endtask : t_writes
  task automatic t_reads(input logic s);
    h.set_style(s);
    k = n_taken;
    h.xfer(1'b1, 1'b0, 1'b1, 8'h00, q);
    chk({1'b0, q}, {1'b0, status}, "status read");
    h.xfer(1'b1, 1'b1, 1'b1, 8'h00, q);
    chk({1'b0, q}, {1'b0, rbyte}, "data read");
    h.xfer(1'b1, 1'b1, 1'b0, 8'h00, q);
    chk(9'(n_taken - k), 9'h001, "read taken count");
  endtask : t_reads
  // Overfill while the sink stalls, then drain
  task automatic t_fill();
    @(posedge clk) ready <= 1'b0;
    got.delete();
    n_ovr = 0;
    for (int i = 0; i < DEPTH + 3; i++) h.xfer(1'b0, 1'b0, 1'b1, 8'h10 + 8'(i), q);
    chk({8'h00, bufr}, 9'h000, "buffer full flag");
    chk(9'(n_ovr != 0), 9'h001, "overrun pulse");
    @(posedge clk) ready <= 1'b1;
    repeat (20) @(posedge clk);
    chk(9'(got.size() + n_ovr), 9'(DEPTH + 3), "words and losses");
    for (int i = 0; i < got.size(); i++) chk(got[i], 9'h010 + 9'(i), "order");
    chk({8'h00, val}, 9'h000, "drained");
    chk({8'h00, bufr}, 9'h001, "buffer free flag");
  endtask : t_fill
  task automatic t_pin_reset();
    h.set_rst(1'b0);
    repeat (8) @(posedge clk);
    chk({8'h00, inrst}, 9'h001, "held in reset");
    got.delete();
    h.xfer(1'b0, 1'b1, 1'b1, 8'h77, q);
    h.set_rst(1'b1);
    repeat (8) @(posedge clk);
    chk({8'h00, inrst}, 9'h000, "reset released");
    chk(9'(got.size()), 9'h000, "write under reset");
  endtask : t_pin_reset
  initial begin
    srst  = 1'b1;
    ready = 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    t_writes(LMP_STYLE_STROBE);
    t_writes(LMP_STYLE_ENABLE);
    t_reads(LMP_STYLE_STROBE);
    t_reads(LMP_STYLE_ENABLE);
    t_fill();
    t_pin_reset();
    report_and_stop();
  end
endmodule : testbench
bind lmp_host_port lmp_host_port_asserts u_chk (.i_ref_clk, .i_srst, .i_reset_n,
  .i_chip_select_n, .i_register_select, .i_bus_style_select, .i_write_n_dir,
  .i_read_n_enable, .o_data_bus, .o_data_bus_oe, .o_wr_valid, .i_wr_ready,
  .o_wr_is_command, .o_wr_data, .i_status_byte, .i_read_byte, .o_read_taken, .o_in_reset);
`default_nettype wire
